// >>> src/tw_pkg.sv
package tw_pkg;

    // ==========================================================
    // widths
    localparam int CNT_W = 16;
    localparam int PRE_W = 8;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // ==========================================================
    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_CNT_HI = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_CNT_LO = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_PRESC = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_SYS = 3'h4;

    // ==========================================================
    // reset values
    localparam logic [DATA_W-1:0] RST_CTRL = 8'h12;
    localparam logic [DATA_W-1:0] RST_CNT_HI = 8'hFF;
    localparam logic [DATA_W-1:0] RST_CNT_LO = 8'hFF;
    localparam logic [DATA_W-1:0] RST_PRESC = 8'hFF;
    localparam logic RST_GUARD_OFF = 1'b1;
    localparam logic RST_A0_SEL = 1'b1;
    localparam logic RST_TOP_SEL = 1'b1;

    // ==========================================================
    // system register field positions
    localparam int SYS_GUARD_OFF = 0;
    localparam int SYS_A0_SEL = 1;
    localparam int SYS_TOP_SEL = 2;
    localparam int SYS_GUARD_ON = 3;
    localparam int SYS_PENDING = 4;

    // ==========================================================
    // timing
    localparam int INT_DIV = 4;
    localparam logic [1:0] DIV_LAST = 2'(INT_DIV - 1);
    localparam int MIN_EDGE_SPACING = 8;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        IN_EVENT,
        IN_GATED,
        IN_TRIG,
        IN_RETRIG
    } tw_in_mode_t;

    typedef struct packed {
        logic run;
        logic single;
        tw_in_mode_t inMode;
        logic input_enable_bit;
        logic outMode;
        logic outLevel;
        logic output_enable_bit;
    } tw_ctrl_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } tw_bus_req_t;

endpackage

// >>> src/tw_in_sync.sv
`timescale 1ns/100ps
`default_nettype none

module tw_in_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] fall
);

    // ==========================================================
    // two-flop synchroniser plus edge stage, per bit
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            logic meta_ff;
            logic sync_ff;
            logic prev_ff;

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_ff <= 1'b1;
                    sync_ff <= 1'b1;
                    prev_ff <= 1'b1;
                end else begin
                    meta_ff <= pinIn[i];
                    sync_ff <= meta_ff;
                    prev_ff <= sync_ff;
                end
            end

            assign level[i] = sync_ff;
            assign fall[i] = prev_ff & ~sync_ff;
        end
    endgenerate

endmodule

`default_nettype wire

// >>> src/tw_timer_guard.sv
// Notes on behaviour
// R1: 16-bit down-counter fed through an 8-bit prescaler.
// R2: count source is the timer input pin or the clock divided by four.
// R3: setting run starts counting next cycle; clearing run stops it.
// R4: restart resumes from held value unless a new constant was written.
// R5: constant written while running loads at next end of count; prescaler at once.
// R6: end of count is when the counter is zero.
// R7: in watchdog mode the run bit is ignored.
// R8: single/continuous bit writable anytime, together with run in one write.
// R9: single mode end of count stops, reloads and clears run bit.
// R10: constant changed while stopped is loaded when counting restarts.
// R11: continuous mode reloads and keeps counting until run is cleared.
// R12: input enable selects pin pulses, otherwise clock divided by four.
// R13: event mode counts each falling edge; source spaces them eight clocks.
// R14: event counting begins at first edge after run set, ends on clear.
// R15: gated mode counts divided clock only while pin high and run set.
// R16: triggerable mode starts on first falling edge after run is set.
// R17: retriggerable mode restarts from constant on falling edges while running.
// R18: output disabled drives the output pin high.
// R19: square wave mode toggles the output pin at each end of count.
// R20: software loads prescaler and counter first, else reset values apply.
// R21: end of count routes to top-level or channel A0, replacing external input.
// R22: hardware select pin can permanently force watchdog mode.
// R23: prescaler divides by stored value plus one, 1 to 256.
// R24: two-bit input mode field in the control register selects input mode.
`timescale 1ns/100ps
`default_nettype none

module tw_timer_guard (
    input wire logic clk,
    input wire logic rst_n,
    input wire tw_pkg::tw_bus_req_t busReq,
    output logic [tw_pkg::DATA_W-1:0] rdata,
    input wire logic timerInputPin,
    input wire logic extInterruptZeroInput,
    input wire logic hwSwGuardSelect,
    output logic timerOutputPin,
    output logic topLevelIrq,
    output logic channelA0Irq,
    output logic guardExpire
);

    // ==========================================================
    // pin synchronisers
    logic [2:0] pinLevel;
    logic [2:0] pinFall;

    tw_in_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn({hwSwGuardSelect, extInterruptZeroInput, timerInputPin}),
        .level(pinLevel),
        .fall(pinFall)
    );

    logic inLevel;
    logic inFall;
    logic extLevel;
    logic selLevel;

    assign inLevel = pinLevel[0];
    assign inFall = pinFall[0];
    assign extLevel = pinLevel[1];
    assign selLevel = pinLevel[2];

    // ==========================================================
    // state
    tw_pkg::tw_ctrl_t ctrl_ff;
    logic [tw_pkg::DATA_W-1:0] constHi_ff;
    logic [tw_pkg::DATA_W-1:0] constLo_ff;
    logic [tw_pkg::PRE_W-1:0] presc_ff;
    logic [tw_pkg::CNT_W-1:0] cnt_ff;
    logic [tw_pkg::PRE_W-1:0] pcnt_ff;
    logic [1:0] div_ff;
    logic pend_ff;
    logic armed_ff;
    logic runPrev_ff;
    logic guardOff_ff;
    logic hwGuard_ff;
    logic a0Sel_ff;
    logic topSel_ff;
    logic outPin_ff;
    logic topIrq_ff;
    logic a0Irq_ff;
    logic expire_ff;
    logic [tw_pkg::DATA_W-1:0] rdata_ff;

    // ==========================================================
    // decode
    logic wrCtrl;
    logic wrHi;
    logic wrLo;
    logic wrPresc;
    logic wrSys;
    logic guardMode;
    logic active;
    logic useInput;
    logic divTick;
    logic srcTick;
    logic retrig;
    logic preWrap;
    logic eoc;
    logic startEdge;
    logic timerEvent;
    logic [tw_pkg::CNT_W-1:0] constVal;

    assign wrCtrl = busReq.wr && (busReq.addr == tw_pkg::ADDR_CTRL);
    assign wrHi = busReq.wr && (busReq.addr == tw_pkg::ADDR_CNT_HI);
    assign wrLo = busReq.wr && (busReq.addr == tw_pkg::ADDR_CNT_LO);
    assign wrPresc = busReq.wr && (busReq.addr == tw_pkg::ADDR_PRESC);
    assign wrSys = busReq.wr && (busReq.addr == tw_pkg::ADDR_SYS);

    assign guardMode = hwGuard_ff | ~guardOff_ff; // R22
    assign active = guardMode | ctrl_ff.run; // R3 R7
    assign useInput = ctrl_ff.input_enable_bit & ~guardMode; // R12
    assign divTick = (div_ff == tw_pkg::DIV_LAST); // R2
    assign constVal = {constHi_ff, constLo_ff};
    assign startEdge = ctrl_ff.run & ~runPrev_ff;

    // ==========================================================
    // count source selection
    always_comb begin
        srcTick = 1'b0;
        if (!active) begin
            srcTick = 1'b0;
        end else if (!useInput) begin
            srcTick = divTick; // R12
        end else begin
            case (ctrl_ff.inMode) // R24
                tw_pkg::IN_EVENT: begin
                    srcTick = inFall; // R13 R14
                end
                tw_pkg::IN_GATED: begin
                    srcTick = divTick & inLevel; // R15
                end
                tw_pkg::IN_TRIG: begin
                    srcTick = divTick & armed_ff; // R16
                end
                tw_pkg::IN_RETRIG: begin
                    srcTick = divTick; // R17
                end
                default: begin
                    srcTick = 1'b0;
                end
            endcase
        end
    end

    assign retrig = active & useInput & (ctrl_ff.inMode == tw_pkg::IN_RETRIG) & inFall; // R17
    assign preWrap = srcTick & (pcnt_ff == '0); // R23
    assign eoc = preWrap & (cnt_ff == '0); // R6
    assign timerEvent = eoc & ~guardMode;

    // ==========================================================
    // internal divider
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= 2'h0;
        end else begin
            div_ff <= div_ff + 2'h1; // R2
        end
    end

    // ==========================================================
    // prescaler
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_ff <= tw_pkg::RST_PRESC;
        end else if (wrPresc) begin
            presc_ff <= busReq.wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pcnt_ff <= tw_pkg::RST_PRESC;
        end else if (wrPresc) begin
            pcnt_ff <= busReq.wdata; // R5
        end else if (retrig) begin
            pcnt_ff <= presc_ff; // R17
        end else if (srcTick) begin
            pcnt_ff <= (pcnt_ff == '0) ? presc_ff : pcnt_ff - 8'h01; // R1 R23
        end
    end

    // ==========================================================
    // counter constant and pending flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            constHi_ff <= tw_pkg::RST_CNT_HI;
            constLo_ff <= tw_pkg::RST_CNT_LO;
        end else if (!guardMode) begin
            if (wrHi) begin
                constHi_ff <= busReq.wdata;
            end
            if (wrLo) begin
                constLo_ff <= busReq.wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_ff <= 1'b0;
        end else if ((wrHi || wrLo) && !guardMode) begin
            pend_ff <= 1'b1; // R4 R10
        end else if (retrig || eoc || startEdge) begin
            pend_ff <= 1'b0;
        end
    end

    // ==========================================================
    // main counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= {tw_pkg::RST_CNT_HI, tw_pkg::RST_CNT_LO}; // R20
        end else if (retrig) begin
            cnt_ff <= constVal; // R17
        end else if (startEdge && pend_ff && !guardMode) begin
            cnt_ff <= constVal; // R4 R10
        end else if (eoc) begin
            cnt_ff <= constVal; // R5 R9 R11
        end else if (preWrap) begin
            cnt_ff <= cnt_ff - 16'h0001; // R1
        end
    end

    // ==========================================================
    // control register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= tw_pkg::tw_ctrl_t'(tw_pkg::RST_CTRL);
        end else if (wrCtrl) begin
            ctrl_ff <= tw_pkg::tw_ctrl_t'(busReq.wdata); // R3 R8
        end else if (timerEvent && ctrl_ff.single) begin
            ctrl_ff.run <= 1'b0; // R9
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            runPrev_ff <= 1'b0;
        end else begin
            runPrev_ff <= ctrl_ff.run;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_ff <= 1'b0;
        end else if (!ctrl_ff.run) begin
            armed_ff <= 1'b0; // R16
        end else if (inFall) begin
            armed_ff <= 1'b1; // R16
        end
    end

    // ==========================================================
    // watchdog enable and interrupt routing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hwGuard_ff <= 1'b0;
        end else if (!selLevel) begin
            hwGuard_ff <= 1'b1; // R22
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            guardOff_ff <= tw_pkg::RST_GUARD_OFF;
            a0Sel_ff <= tw_pkg::RST_A0_SEL;
            topSel_ff <= tw_pkg::RST_TOP_SEL;
        end else if (wrSys) begin
            guardOff_ff <= guardOff_ff & busReq.wdata[tw_pkg::SYS_GUARD_OFF];
            a0Sel_ff <= busReq.wdata[tw_pkg::SYS_A0_SEL];
            topSel_ff <= busReq.wdata[tw_pkg::SYS_TOP_SEL];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a0Irq_ff <= 1'b0;
            topIrq_ff <= 1'b0;
            expire_ff <= 1'b0;
        end else begin
            a0Irq_ff <= a0Sel_ff ? ~extLevel : timerEvent; // R21
            // both selects low: only channel A0 takes the timer event
            topIrq_ff <= topSel_ff ? ~extLevel : (timerEvent & a0Sel_ff); // R21
            expire_ff <= eoc & guardMode;
        end
    end

    // ==========================================================
    // output pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            outPin_ff <= 1'b1;
        end else if (!ctrl_ff.output_enable_bit) begin
            outPin_ff <= 1'b1; // R18
        end else if (eoc) begin
            outPin_ff <= ctrl_ff.outMode ? ctrl_ff.outLevel : ~outPin_ff; // R19
        end
    end

    // ==========================================================
    // read port
    logic [tw_pkg::DATA_W-1:0] readMux;

    always_comb begin
        readMux = 8'h00;
        case (busReq.addr)
            tw_pkg::ADDR_CTRL: begin
                readMux = ctrl_ff; // R9
            end
            tw_pkg::ADDR_CNT_HI: begin
                readMux = cnt_ff[15:8];
            end
            tw_pkg::ADDR_CNT_LO: begin
                readMux = cnt_ff[7:0];
            end
            tw_pkg::ADDR_PRESC: begin
                readMux = presc_ff;
            end
            tw_pkg::ADDR_SYS: begin
                readMux[tw_pkg::SYS_GUARD_OFF] = guardOff_ff;
                readMux[tw_pkg::SYS_A0_SEL] = a0Sel_ff;
                readMux[tw_pkg::SYS_TOP_SEL] = topSel_ff;
                readMux[tw_pkg::SYS_GUARD_ON] = guardMode;
                readMux[tw_pkg::SYS_PENDING] = pend_ff;
            end
            default: begin
                readMux = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= busReq.rd ? readMux : 8'h00;
        end
    end

    assign rdata = rdata_ff;
    assign timerOutputPin = outPin_ff;
    assign topLevelIrq = topIrq_ff;
    assign channelA0Irq = a0Irq_ff;
    assign guardExpire = expire_ff;

endmodule

`default_nettype wire

// >>> verification/tw_pin_source.sv
`timescale 1ns/100ps
`default_nettype none
module tw_pin_source (
    input wire logic clk,
    input wire logic pulsing,
    input wire logic [7:0] gap,
    output logic pin
);
    logic [7:0] cnt;
    initial begin
        pin = 1'b1;
        cnt = 8'h00;
    end
    // one falling edge every gap clocks, idle high
    always @(posedge clk) begin
        if (!pulsing) begin
            pin <= 1'b1;
            cnt <= 8'h00;
        end else begin
            cnt <= (cnt + 8'h01 >= gap) ? 8'h00 : cnt + 8'h01;
            pin <= cnt < (gap >> 1);
        end
    end
endmodule
`default_nettype wire

// >>> verification/tw_timer_guard_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module tw_timer_guard_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire tw_pkg::tw_bus_req_t busReq,
    input wire logic [tw_pkg::DATA_W-1:0] rdata,
    input wire logic timerInputPin,
    input wire logic extInterruptZeroInput,
    input wire logic hwSwGuardSelect,
    input wire logic timerOutputPin,
    input wire logic topLevelIrq,
    input wire logic channelA0Irq,
    input wire logic guardExpire
);
    // ==========================================
    // shadow of software settings
    tw_pkg::tw_ctrl_t ctrl_ff;
    logic [2:0] sys_ff;
    logic guard, tmrA0, sq, evt, gat;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= tw_pkg::tw_ctrl_t'(tw_pkg::RST_CTRL);
            sys_ff <= 3'h7;
        end else if (busReq.wr && busReq.addr == tw_pkg::ADDR_CTRL) begin
            ctrl_ff <= tw_pkg::tw_ctrl_t'(busReq.wdata);
        end else if (busReq.wr && busReq.addr == tw_pkg::ADDR_SYS) begin
            sys_ff <= busReq.wdata[2:0] & {2'h3, sys_ff[0]};
        end
    end
    assign guard = !sys_ff[0] || !hwSwGuardSelect;
    assign tmrA0 = !sys_ff[1] && !guard;
    assign sq = tmrA0 && ctrl_ff.output_enable_bit && !ctrl_ff.outMode;
    assign evt = tmrA0 && ctrl_ff.input_enable_bit && ctrl_ff.inMode == tw_pkg::IN_EVENT;
    assign gat = tmrA0 && ctrl_ff.input_enable_bit && ctrl_ff.inMode == tw_pkg::IN_GATED;

    // ==========================================
    // properties
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    property p_outOff;
        !ctrl_ff.output_enable_bit && !$past(ctrl_ff.output_enable_bit) |-> timerOutputPin;
    endproperty
    a_outOff: assert property (p_outOff) else $error("output pin low while disabled");
    property p_sqWave;
        sq && $past(sq) && $past(sq, 2) |-> $changed(timerOutputPin) == channelA0Irq;
    endproperty
    a_sqWave: assert property (p_sqWave) else $error("square wave not tied to end of count");
    property p_topAct;
        (sys_ff[2] && !extInterruptZeroInput) [*5] |-> topLevelIrq;
    endproperty
    a_topAct: assert property (p_topAct) else $error("external pin not routed to top level");
    property p_guardQuiet;
        !guard && !$past(guard) |-> !guardExpire;
    endproperty
    a_guardQuiet: assert property (p_guardQuiet) else $error("expiry outside watchdog mode");
    property p_stopped;
        (tmrA0 && !ctrl_ff.run) [*3] |-> !channelA0Irq;
    endproperty
    a_stopped: assert property (p_stopped) else $error("end of count while stopped");
    property p_single;
        $rose(channelA0Irq) && ctrl_ff.single && tmrA0 |=> (!channelA0Irq) [*8];
    endproperty
    a_single: assert property (p_single) else $error("single mode kept counting");
    property p_event;
        (evt && timerInputPin) [*8] |-> !channelA0Irq;
    endproperty
    a_event: assert property (p_event) else $error("event count without falling edge");
    property p_gated;
        (gat && !timerInputPin) [*8] |-> !channelA0Irq;
    endproperty
    a_gated: assert property (p_gated) else $error("gated count with pin low");
endmodule
bind tw_timer_guard tw_timer_guard_asserts tw_timer_guard_asserts_inst (.clk(clk), .rst_n(rst_n),
    .busReq(busReq), .rdata(rdata), .timerInputPin(timerInputPin),
    .extInterruptZeroInput(extInterruptZeroInput), .hwSwGuardSelect(hwSwGuardSelect),
    .timerOutputPin(timerOutputPin), .topLevelIrq(topLevelIrq), .channelA0Irq(channelA0Irq),
    .guardExpire(guardExpire));
`default_nettype wire

// >>> verification/tb_tw_timer_guard.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
    $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module tb_tw_timer_guard;
    logic clk;
    logic rst_n;
    tw_pkg::tw_bus_req_t busReq;
    logic [7:0] rdata;
    logic pin, ext, pulsing, tout, topIrq, a0Irq, gExp;
    logic hwSel;
    logic [31:0] lfsr;
    logic [7:0] rv [6] = '{8'h12, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h00};
    int fails;
    int samples_checked;

    tw_timer_guard tw_timer_guard_inst (.clk(clk), .rst_n(rst_n), .busReq(busReq), .rdata(rdata),
        .timerInputPin(pin), .extInterruptZeroInput(ext), .hwSwGuardSelect(hwSel),
        .timerOutputPin(tout), .topLevelIrq(topIrq), .channelA0Irq(a0Irq), .guardExpire(gExp));
    tw_pin_source tw_pin_source_inst (.clk(clk), .pulsing(pulsing), .gap(8'h14), .pin(pin));

    function automatic logic [31:0] nxtLfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int per(input int c, input int p, input int s);
        return (c + 1) * (p + 1) * s;
    endfunction

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        lfsr <= nxtLfsr(lfsr);
        if (lfsr[3:0] == 4'h0) ext <= lfsr[9];
    end

    // ==========================================
    // bus and measurement tasks
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        busReq <= {1'b0, 1'b1, a, d};
        @(posedge clk);
        busReq.wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        busReq <= {1'b1, 1'b0, a, 8'h00};
        @(posedge clk);
        busReq.rd <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask
    // interval between second and third pulse; the waits before it may straddle a reload
    task automatic meas(input int exp, input logic g);
        int n;
        logic t;
        t = 1'b0;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while ((g ? gExp : a0Irq) !== 1'b1 && n < 3000);
            if (k == 2) `CHK(n, exp)
            if (k == 2 && !g) `CHK(tout, ~t)
            t = tout;
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        end_of_test();
    end

    // ==========================================
    // main sequence
    initial begin
        logic [7:0] v;
        logic [7:0] u;
        logic [7:0] ctl;
        int c;
        int p;
        int s;
        rst_n = 1'b0;
        busReq = '0;
        ext = 1'b1;
        pulsing = 1'b0;
        hwSel = 1'b1;
        lfsr = 32'h28C0DD9A;
        fails = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 6; a++) begin
            rd(3'(a), v);
            `CHK(v, rv[a])
        end
        wr(tw_pkg::ADDR_SYS, 8'h05);
        // internal, event, gated, triggerable, retriggerable
        for (int i = 0; i < 5; i++) begin
            c = int'(lfsr[1:0]);
            p = int'(lfsr[5:4]);
            s = (i == 1) ? 20 : 4;
            ctl = (i == 0) ? 8'h81 : 8'h89 | 8'((i - 1) << 4);
            wr(tw_pkg::ADDR_CNT_HI, 8'h00);
            wr(tw_pkg::ADDR_CNT_LO, 8'(c));
            wr(tw_pkg::ADDR_PRESC, 8'(p));
            wr(tw_pkg::ADDR_CTRL, ctl);
            pulsing <= (i != 2);
            if (i > 2) begin
                repeat (14) @(posedge clk);
                pulsing <= 1'b0;
            end
            meas(per(c, p, s), 1'b0);
            c = int'(lfsr[9:8]);
            p = int'(lfsr[13:12]);
            wr(tw_pkg::ADDR_PRESC, 8'(p));
            wr(tw_pkg::ADDR_CNT_LO, 8'(c));
            meas(per(c, p, s), 1'b0);
            wr(tw_pkg::ADDR_CTRL, ctl & 8'h7F);
            pulsing <= 1'b1;
            rd(tw_pkg::ADDR_CNT_LO, v);
            repeat (20) @(posedge clk);
            rd(tw_pkg::ADDR_CNT_LO, u);
            `CHK(u, v)
            pulsing <= 1'b0;
        end
        wr(tw_pkg::ADDR_CNT_LO, 8'h02);
        wr(tw_pkg::ADDR_PRESC, 8'h00);
        wr(tw_pkg::ADDR_CTRL, 8'hC1);
        c = 0;
        while (a0Irq !== 1'b1 && c < 200) begin
            @(negedge clk);
            c++;
        end
        repeat (10) @(negedge clk);
        rd(tw_pkg::ADDR_CTRL, v);
        `CHK(v, 8'h41)
        rd(tw_pkg::ADDR_CNT_LO, v);
        `CHK(v, 8'h02)
        wr(tw_pkg::ADDR_SYS, 8'h04);
        meas(per(2, 0, 4), 1'b1);
        // second reset, then the select pin forces watchdog mode
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        hwSel <= 1'b0;
        repeat (4) @(posedge clk);
        rd(tw_pkg::ADDR_SYS, v);
        `CHK(v, 8'h0F)
        wr(tw_pkg::ADDR_CNT_HI, 8'h00);
        rd(tw_pkg::ADDR_SYS, v);
        `CHK(v, 8'h0F)
        rd(tw_pkg::ADDR_CNT_HI, v);
        `CHK(v, 8'hFF)
        end_of_test();
    end
endmodule
`default_nettype wire
